// file: pssq_pkg.sv
package pssq_pkg;

  localparam int PC_W      = 12;
  localparam int ROM_W     = 15;
  localparam int DATA_W    = 8;
  localparam int STACK_DEP = 4;

  localparam logic [11:0] RESET_VECTOR = 12'h000;
  localparam logic [11:0] USB_VECTOR   = 12'h004;
  localparam logic [11:0] TIMER_VECTOR = 12'h00c;
  localparam logic [3:0]  LAST_PAGE    = 4'hf;

  localparam logic [7:0] PCL_ADDR   = 8'h06;
  localparam logic [7:0] TABLE_POINTER_LOW_ADDR  = 8'h07;
  localparam logic [7:0] TABLE_RESULT_HIGH_ADDR  = 8'h08;
  localparam logic [7:0] TABLE_POINTER_HIGH_ADDR  = 8'h1f;
  localparam logic [7:0] GP_BASE    = 8'h20;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;

  localparam logic [7:0] TABLE_POINTER_LOW_RESET = 8'h00;
  localparam logic [7:0] TABLE_POINTER_HIGH_RESET = 8'h00;
  localparam logic [7:0] TABLE_RESULT_HIGH_RESET = 8'h00;

  localparam logic [1:0] PHASE_LAST   = 2'h3;
  localparam int         PHASES_PER_CYCLE = 4;

  typedef enum logic [2:0] {
    PSSQ_OP_NEXT,
    PSSQ_OP_JUMP,
    PSSQ_OP_CALL,
    PSSQ_OP_RET,
    PSSQ_OP_INTERRUPT_RETURN,
    PSSQ_OP_SKIP,
    PSSQ_OP_TABC,
    PSSQ_OP_TABL
  } pssq_op_type;

  typedef struct packed {
    pssq_op_type op;
    logic [11:0] target;
    logic [7:0]  dest;
  } pssq_cmd_type;

  typedef struct packed {
    logic       we;
    logic       re;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       bit_op;
    logic [2:0] bit_sel;
    logic       bit_val;
  } pssq_mem_req_type;

endpackage

// file: pssq_stack.sv
`timescale 1ns/100ps
module pssq_stack #(
  parameter int DEPTH = pssq_pkg::STACK_DEP,
  parameter int WIDTH = pssq_pkg::PC_W
) (
  input  wire logic             mclk_i,  // System clock.
  input  wire logic             rst_i,   // Asynchronous reset.
  input  wire logic             push_i,  // Push request.
  input  wire logic             pop_i,   // Pop request.
  input  wire logic [WIDTH-1:0] data_i,  // Value to push.
  output logic      [WIDTH-1:0] top_o,   // Most recent entry.
  output logic                  full_o,  // All levels in use.
  output logic                  empty_o  // No level in use.
);
  localparam int IW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [IW-1:0]    stack_index;
  logic [IW:0]      fill;

  // A full push wraps and overwrites the oldest slot.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      stack_index <= '0;
      fill        <= '0;
    end else if (push_i) begin
      stack_index <= stack_index + 1'b1;
      if (fill != (IW+1)'(DEPTH)) begin
        fill <= fill + 1'b1;
      end
    end else if (pop_i && fill != '0) begin
      stack_index <= stack_index - 1'b1;
      fill        <= fill - 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (push_i) begin
      mem[stack_index] <= data_i;
    end
  end

  assign top_o   = mem[stack_index - 1'b1];
  assign full_o  = (fill == (IW+1)'(DEPTH));
  assign empty_o = (fill == '0);
endmodule

// file: pssq_data_mem.sv
`timescale 1ns/100ps
module pssq_data_mem (
  input  wire logic                      mclk_i,   // System clock.
  input  wire pssq_pkg::pssq_mem_req_type req_i,   // General purpose access.
  output logic                     [7:0] rdata_o   // Read data, one cycle later.
);
  logic [7:0] mem [224];
  logic [7:0] idx;

  assign idx = req_i.addr - pssq_pkg::GP_BASE;

  always_ff @(posedge mclk_i) begin
    if (req_i.we && req_i.addr >= pssq_pkg::GP_BASE) begin
      if (req_i.bit_op) begin
        mem[idx][req_i.bit_sel] <= req_i.bit_val;
      end else begin
        mem[idx] <= req_i.wdata;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (req_i.addr >= pssq_pkg::GP_BASE) begin
      rdata_o <= mem[idx];
    end else begin
      rdata_o <= pssq_pkg::ZERO_BYTE;
    end
  end
endmodule

// file: pssq_sequencer.sv
`timescale 1ns/100ps
module pssq_sequencer #(
  parameter bit TABLE_POINTER_HIGH_OPTION = 1'b0
) (
  input  wire logic                      mclk_i,        // 200 MHz system clock.
  input  wire logic                      rst_i,         // Asynchronous reset.
  output logic                    [11:0] rom_addr_o,    // Program memory address.
  input  wire logic               [14:0] rom_data_i,    // Program memory word.
  output logic                    [14:0] instr_o,       // Fetched word to decode.
  output logic                           instr_valid_o, // Pulse: execute slot start.
  input  wire pssq_pkg::pssq_cmd_type    cmd_i,         // Decoded command of current word.
  input  wire logic                      skip_cond_i,   // Skip condition holds.
  input  wire pssq_pkg::pssq_mem_req_type mem_i,        // Data memory access.
  output logic                     [7:0] mem_rdata_o,   // Data memory read value.
  input  wire logic                      usb_req_i,     // USB interrupt request pin.
  input  wire logic                      usb_en_i,      // USB interrupt enable.
  input  wire logic                      tmr_req_i,     // Timer overflow request.
  input  wire logic                      tmr_en_i,      // Timer interrupt enable.
  input  wire logic                      int_glob_en_i, // Global interrupt enable.
  output logic                           int_ack_o,     // Pulse: interrupt acknowledged.
  output logic                           usb_pend_o,    // USB request pending.
  output logic                           tmr_pend_o,    // Timer request pending.
  output logic                    [11:0] ip_o,          // Instruction pointer.
  output logic                           stack_full_o   // Stack full.
);
  logic [11:0] instruction_pointer;
  logic [11:0] next_ip;
  logic [1:0]  phase;
  logic        cyc_en;
  logic        dummy;
  logic        tab_second;
  logic [11:0] tab_addr;
  logic [7:0]  tab_dest;
  logic [7:0]  table_pointer_low;
  logic [7:0]  table_pointer_high;
  logic [7:0]  table_result_high;
  logic [2:0]  usb_sync;
  logic        usb_pend;
  logic        tmr_pend;
  logic        push;
  logic        pop;
  logic [11:0] stk_top;
  logic        stk_full;
  logic        take_int;
  logic [11:0] int_vec;
  logic [7:0]  gp_rdata;
  logic [7:0]  sfr_rdata;
  logic        sfr_sel;
  logic        tab_wr;
  pssq_pkg::pssq_mem_req_type gp_req;

  function automatic logic [7:0] apply_write(input logic [7:0] cur,
                                             input pssq_pkg::pssq_mem_req_type r);
    logic [7:0] v;
    v = cur;
    if (r.bit_op) begin
      v[r.bit_sel] = r.bit_val;
    end else begin
      v = r.wdata;
    end
    return v;
  endfunction

  function automatic logic wr_hit(input pssq_pkg::pssq_mem_req_type r,
                                  input logic [7:0] a);
    return r.we && (r.addr == a);
  endfunction

  // Four clocks make one instruction cycle; pointer, fetch and slot state step on the last phase.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end
  assign cyc_en = (phase == pssq_pkg::PHASE_LAST);

  // The USB request is a pin, so it is synchronised before use.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      usb_sync <= 3'h0;
    end else begin
      usb_sync <= {usb_sync[1:0], usb_req_i};
    end
  end

  // Request flags: a new request wins over the clear by acknowledge.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      usb_pend <= 1'b0;
      tmr_pend <= 1'b0;
    end else begin
      if (usb_sync[1] && usb_sync[2]) begin
        usb_pend <= 1'b1;
      end else if (take_int && usb_pend && usb_en_i) begin
        usb_pend <= 1'b0;
      end
      if (tmr_req_i) begin
        tmr_pend <= 1'b1;
      end else if (take_int && !(usb_pend && usb_en_i)) begin
        tmr_pend <= 1'b0;
      end
    end
  end

  // Acknowledge only when the stack has room and no dummy or table slot runs.
  assign take_int = cyc_en && !dummy && !tab_second && int_glob_en_i && !stk_full
                    && ((usb_pend && usb_en_i) || (tmr_pend && tmr_en_i));
  assign int_vec  = (usb_pend && usb_en_i) ? pssq_pkg::USB_VECTOR
                                           : pssq_pkg::TIMER_VECTOR;

  always_comb begin
    tab_addr = {instruction_pointer[11:8], table_pointer_low};
    if (cmd_i.op == pssq_pkg::PSSQ_OP_TABL) begin
      tab_addr = {pssq_pkg::LAST_PAGE, table_pointer_low};
    end else if (TABLE_POINTER_HIGH_OPTION) begin
      tab_addr = {table_pointer_high[3:0], table_pointer_low};
    end
  end

  // Next pointer value chosen once per instruction cycle.
  always_comb begin
    next_ip = instruction_pointer + 12'h001;
    push    = 1'b0;
    pop     = 1'b0;
    if (take_int) begin
      next_ip = int_vec;
      push    = 1'b1;
    end else if (!dummy && !tab_second) begin
      if (wr_hit(mem_i, pssq_pkg::PCL_ADDR)) begin
        next_ip = {instruction_pointer[11:8], apply_write(instruction_pointer[7:0], mem_i)};
      end else begin
        unique case (cmd_i.op)
          pssq_pkg::PSSQ_OP_JUMP: next_ip = cmd_i.target;
          pssq_pkg::PSSQ_OP_CALL: begin
            next_ip = cmd_i.target;
            push    = 1'b1;
          end
          pssq_pkg::PSSQ_OP_RET,
          pssq_pkg::PSSQ_OP_INTERRUPT_RETURN: begin
            next_ip = stk_top;
            pop     = 1'b1;
          end
          pssq_pkg::PSSQ_OP_TABC,
          pssq_pkg::PSSQ_OP_TABL: next_ip = instruction_pointer;
          pssq_pkg::PSSQ_OP_SKIP,
          pssq_pkg::PSSQ_OP_NEXT: next_ip = instruction_pointer + 12'h001;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      instruction_pointer <= pssq_pkg::RESET_VECTOR;
    end else if (cyc_en) begin
      instruction_pointer <= next_ip;
    end
  end

  // The word already fetched is void after a transfer or a met skip.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      dummy <= 1'b1;
    end else if (cyc_en) begin
      dummy <= take_int || (!dummy && !tab_second && (push || pop
               || cmd_i.op == pssq_pkg::PSSQ_OP_JUMP
               || wr_hit(mem_i, pssq_pkg::PCL_ADDR)
               || (cmd_i.op == pssq_pkg::PSSQ_OP_SKIP && skip_cond_i)));
    end
  end

  // Second cycle of a table read holds the table address on the ROM port.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tab_second <= 1'b0;
      tab_dest   <= 8'h00;
    end else if (cyc_en) begin
      tab_second <= !take_int && !dummy && !tab_second
                    && (cmd_i.op == pssq_pkg::PSSQ_OP_TABC || cmd_i.op == pssq_pkg::PSSQ_OP_TABL);
      tab_dest   <= cmd_i.dest;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rom_addr_o <= pssq_pkg::RESET_VECTOR;
    end else if (cyc_en) begin
      // Decided by the command itself, so a low byte write to the same value is not a table read.
      rom_addr_o <= (!take_int && !dummy && !tab_second && !wr_hit(mem_i, pssq_pkg::PCL_ADDR)
                     && (cmd_i.op == pssq_pkg::PSSQ_OP_TABC || cmd_i.op == pssq_pkg::PSSQ_OP_TABL))
                    ? tab_addr : next_ip;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      instr_o       <= 15'h0000;
      instr_valid_o <= 1'b0;
      int_ack_o     <= 1'b0;
    end else begin
      instr_valid_o <= cyc_en;
      int_ack_o     <= take_int;
      if (cyc_en) begin
        instr_o <= rom_data_i;
      end
    end
  end

  assign tab_wr = cyc_en && tab_second;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      table_pointer_low  <= pssq_pkg::TABLE_POINTER_LOW_RESET;
      table_pointer_high <= pssq_pkg::TABLE_POINTER_HIGH_RESET;
      table_result_high  <= pssq_pkg::TABLE_RESULT_HIGH_RESET;
    end else begin
      if (wr_hit(mem_i, pssq_pkg::TABLE_POINTER_LOW_ADDR)) begin
        table_pointer_low <= apply_write(table_pointer_low, mem_i);
      end
      if (wr_hit(mem_i, pssq_pkg::TABLE_POINTER_HIGH_ADDR)) begin
        table_pointer_high <= apply_write(table_pointer_high, mem_i);
      end
      if (tab_wr) begin
        table_result_high <= {1'b0, rom_data_i[14:8]};
      end
    end
  end

  // The table low byte shares the general memory write port.
  always_comb begin
    gp_req = mem_i;
    if (tab_wr) begin
      gp_req.we     = 1'b1;
      gp_req.addr   = tab_dest;
      gp_req.wdata  = rom_data_i[7:0];
      gp_req.bit_op = 1'b0;
    end
  end

  pssq_stack u_stack (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .push_i  (push && cyc_en),
    .pop_i   (pop && cyc_en),
    .data_i  (take_int ? instruction_pointer : instruction_pointer + 12'h001),
    .top_o   (stk_top),
    .full_o  (stk_full),
    .empty_o ()
  );

  pssq_data_mem u_mem (
    .mclk_i  (mclk_i),
    .req_i   (gp_req),
    .rdata_o (gp_rdata)
  );

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sfr_sel   <= 1'b0;
      sfr_rdata <= 8'h00;
    end else begin
      sfr_sel <= mem_i.addr < pssq_pkg::GP_BASE;
      unique case (mem_i.addr)
        pssq_pkg::PCL_ADDR:  sfr_rdata <= instruction_pointer[7:0];
        pssq_pkg::TABLE_POINTER_LOW_ADDR: sfr_rdata <= table_pointer_low;
        pssq_pkg::TABLE_RESULT_HIGH_ADDR: sfr_rdata <= table_result_high;
        pssq_pkg::TABLE_POINTER_HIGH_ADDR: sfr_rdata <= table_pointer_high;
        default:             sfr_rdata <= pssq_pkg::ZERO_BYTE;
      endcase
    end
  end

  assign mem_rdata_o  = sfr_sel ? sfr_rdata : gp_rdata;
  assign usb_pend_o   = usb_pend;
  assign tmr_pend_o   = tmr_pend;
  assign ip_o         = instruction_pointer;
  assign stack_full_o = stk_full;
endmodule

// file: pssq_sequencer_sva.sv
`timescale 1ns/100ps
module pssq_sequencer_sva (
  input wire logic        mclk_i,        // Clock.
  input wire logic        rst_i,         // Reset.
  input wire logic [11:0] rom_addr_o,    // Fetch address.
  input wire logic [14:0] instr_o,       // Fetched word.
  input wire logic        instr_valid_o, // Slot pulse.
  input wire logic        usb_en_i,      // USB enable.
  input wire logic        tmr_en_i,      // Timer enable.
  input wire logic        int_glob_en_i, // Global enable.
  input wire logic        int_ack_o,     // Acknowledge.
  input wire logic        usb_pend_o,    // USB pending.
  input wire logic        tmr_pend_o,    // Timer pending.
  input wire logic [11:0] ip_o,          // Pointer.
  input wire logic        stack_full_o   // Stack full.
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_slot_period: assert property (instr_valid_o |=> !instr_valid_o [*3] ##1 instr_valid_o)
    else $error("slot pulse spacing wrong");
  a_addr_stands: assert property (instr_valid_o |=> $stable(rom_addr_o) [*3])
    else $error("fetch address moved inside a slot");
  a_word_on_slot: assert property ($changed(instr_o) |-> instr_valid_o)
    else $error("fetched word changed off the slot edge");
  a_ack_spacing: assert property (int_ack_o |=> !int_ack_o [*3])
    else $error("acknowledge pulses too close");
  a_ack_cause: assert property (int_ack_o |-> $past(int_glob_en_i) &&
    ($past(usb_pend_o) && $past(usb_en_i) || $past(tmr_pend_o) && $past(tmr_en_i)))
    else $error("acknowledge without enabled pending request");
  a_usb_vector: assert property (int_ack_o && $past(usb_pend_o) && $past(usb_en_i)
    |-> ip_o == pssq_pkg::USB_VECTOR)
    else $error("USB acknowledge not at its vector");
  a_timer_vector: assert property (int_ack_o && !($past(usb_pend_o) && $past(usb_en_i))
    |-> ip_o == pssq_pkg::TIMER_VECTOR)
    else $error("timer acknowledge not at its vector");
  a_ack_room: assert property (int_ack_o |-> !$past(stack_full_o))
    else $error("acknowledge while stack full");
  a_pend_kept: assert property ($fell(tmr_pend_o) |-> int_ack_o)
    else $error("timer request dropped unserved");
  a_reset_clear: assert property ($fell(rst_i) |-> ip_o == 12'h000 && !stack_full_o)
    else $error("state not cleared by reset");
endmodule
bind pssq_sequencer pssq_sequencer_sva i_pssq_sequencer_sva (.mclk_i(mclk_i), .rst_i(rst_i),
  .rom_addr_o(rom_addr_o), .instr_o(instr_o), .instr_valid_o(instr_valid_o),
  .usb_en_i(usb_en_i), .tmr_en_i(tmr_en_i), .int_glob_en_i(int_glob_en_i),
  .int_ack_o(int_ack_o), .usb_pend_o(usb_pend_o), .tmr_pend_o(tmr_pend_o), .ip_o(ip_o),
  .stack_full_o(stack_full_o));

// file: pssq_rom_model.sv
`timescale 1ns/100ps
module pssq_rom_model #(
  parameter bit SLOW = 1'b0
) (
  input  wire logic        mclk_i, // Clock.
  input  wire logic [11:0] addr_i, // Word address.
  output logic      [14:0] data_o  // Program word.
);
  logic [11:0] last_addr;
  // A fixed pattern lets the bench predict every one of the 4096 words.
  function automatic logic [14:0] word(input logic [11:0] a);
    return {a[6:0], a[11:4]} ^ 15'h2c5a;
  endfunction
  always_ff @(posedge mclk_i) begin
    last_addr <= addr_i;
  end
  // When slow, a fresh address first shows the inverted word, so an early sample is caught.
  assign data_o = (SLOW && last_addr !== addr_i) ? ~word(addr_i) : word(addr_i);
endmodule

// file: program_sequencer_stack_table_read_tb.sv
`timescale 1ns/100ps
module program_sequencer_stack_table_read_tb;
  logic mclk_i = 1'b0, rst_i = 1'b1, skip_cond_i = 1'b0, usb_req_i = 1'b0, tmr_req_i = 1'b0;
  logic usb_en_i = 1'b1, tmr_en_i = 1'b1, int_glob_en_i = 1'b1;
  logic instr_valid_o, int_ack_o, usb_pend_o, tmr_pend_o, stack_full_o;
  logic [11:0] rom_addr_o, ip_o, ack_ip, r[$];
  logic [14:0] rom_data_i, instr_o, w;
  logic [7:0] mem_rdata_o;
  pssq_pkg::pssq_cmd_type cmd_i = '0;
  pssq_pkg::pssq_mem_req_type mem_i = '0;
  int bad_count = 0, check_count = 0, acks = 0;
  typedef struct packed {pssq_pkg::pssq_op_type op; logic [11:0] tg;} pssq_row_type;
  pssq_row_type rows [4] = '{'{pssq_pkg::PSSQ_OP_JUMP, 12'h123}, '{pssq_pkg::PSSQ_OP_JUMP, 12'hfff},
    '{pssq_pkg::PSSQ_OP_JUMP, 12'h000}, '{pssq_pkg::PSSQ_OP_CALL, 12'h456}};
  initial forever #2.5 mclk_i = ~mclk_i;
  pssq_sequencer i_pssq_sequencer (.mclk_i, .rst_i, .rom_addr_o, .rom_data_i, .instr_o,
    .instr_valid_o, .cmd_i, .skip_cond_i, .mem_i, .mem_rdata_o, .usb_req_i, .usb_en_i, .tmr_req_i,
    .tmr_en_i, .int_glob_en_i, .int_ack_o, .usb_pend_o, .tmr_pend_o, .ip_o, .stack_full_o);
  pssq_rom_model #(.SLOW(1'b1)) i_pssq_rom_model (.mclk_i, .addr_i(rom_addr_o), .data_o(rom_data_i));
  always @(posedge mclk_i) begin
    if (int_ack_o === 1'b1) begin
      acks++;
      ack_ip = ip_o;
    end
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [14:0] seen, input logic [14:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Returns at the edge just after a slot boundary, when the last command's effect is settled.
  task automatic issue(input pssq_pkg::pssq_op_type op, input logic [11:0] tg, input logic sk);
    int n;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (instr_valid_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      give_verdict();
    end
    cmd_i <= '{op, tg, 8'h40};
    skip_cond_i <= sk;
  endtask
  task automatic nop(input int k);
    repeat (k) issue(pssq_pkg::PSSQ_OP_NEXT, 12'h000, 1'b0);
  endtask
  task automatic mem(input logic we, input logic [7:0] ad, input logic [7:0] wd, input logic bo,
                     input logic [2:0] bs, input logic bv);
    @(posedge mclk_i);
    mem_i <= '{we, ~we, ad, wd, bo, bs, bv};
    @(posedge mclk_i);
    mem_i <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    mem(1'b0, ad, 8'h00, 1'b0, 3'h0, 1'b0);
    chk("read", 15'(mem_rdata_o), 15'(exp));
  endtask
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    nop(2);
    for (int i = 0; i < 4; i++) begin
      issue(rows[i].op, rows[i].tg, 1'b0);
      nop(1);
      chk("row ip", 15'(ip_o), 15'(rows[i].tg));
      nop(1);
    end
    $display("test rows done");
    w = 15'(ip_o);
    nop(1);
    chk("step", 15'(ip_o), w + 15'h1);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk("reset ip", 15'(ip_o), 15'h0);
    chk("reset stack", 15'(stack_full_o), 15'h0);
    rst_i <= 1'b0;
    rd(pssq_pkg::TABLE_POINTER_LOW_ADDR, pssq_pkg::TABLE_POINTER_LOW_RESET);
    rd(pssq_pkg::TABLE_POINTER_HIGH_ADDR, pssq_pkg::TABLE_POINTER_HIGH_RESET);
    rd(8'h0c, 8'h00);
    mem(1'b1, 8'h80, 8'h5a, 1'b0, 3'h0, 1'b0);
    mem(1'b1, 8'h80, 8'h00, 1'b1, 3'h0, 1'b1);
    mem(1'b1, 8'h80, 8'h00, 1'b1, 3'h1, 1'b0);
    rd(8'h80, 8'h59);
    mem(1'b1, pssq_pkg::TABLE_POINTER_HIGH_ADDR, 8'h0b, 1'b0, 3'h0, 1'b0);
    rd(pssq_pkg::TABLE_POINTER_HIGH_ADDR, 8'h0b);
    $display("test memory done");
    issue(pssq_pkg::PSSQ_OP_JUMP, 12'h300, 1'b0);
    issue(pssq_pkg::PSSQ_OP_JUMP, 12'h7ff, 1'b0);
    nop(2);
    chk("dummy", 15'(ip_o), 15'h302);
    issue(pssq_pkg::PSSQ_OP_SKIP, 12'h000, 1'b1);
    issue(pssq_pkg::PSSQ_OP_JUMP, 12'h222, 1'b0);
    nop(2);
    chk("skip met", 15'(ip_o === 12'h222), 15'h0);
    issue(pssq_pkg::PSSQ_OP_SKIP, 12'h000, 1'b0);
    issue(pssq_pkg::PSSQ_OP_JUMP, 12'h222, 1'b0);
    nop(1);
    chk("skip not met", 15'(ip_o), 15'h222);
    nop(1);
    // The low byte write is an executed instruction, so it must stand at a slot edge.
    mem_i <= '{1'b1, 1'b0, pssq_pkg::PCL_ADDR, 8'h12, 1'b0, 3'h0, 1'b0};
    nop(1);
    mem_i <= '0;
    nop(1);
    chk("short jump", 15'(ip_o), 15'h213);
    $display("test transfers done");
    mem(1'b1, pssq_pkg::TABLE_POINTER_LOW_ADDR, 8'h35, 1'b0, 3'h0, 1'b0);
    issue(pssq_pkg::PSSQ_OP_JUMP, 12'h5a0, 1'b0);
    nop(2);
    issue(pssq_pkg::PSSQ_OP_TABC, 12'h000, 1'b0);
    issue(pssq_pkg::PSSQ_OP_JUMP, 12'habc, 1'b0);
    nop(2);
    chk("table slot", 15'(ip_o[11:8]), 15'h5);
    w = i_pssq_rom_model.word(12'h535);
    rd(8'h40, w[7:0]);
    rd(pssq_pkg::TABLE_RESULT_HIGH_ADDR, {1'b0, w[14:8]});
    mem(1'b1, pssq_pkg::TABLE_RESULT_HIGH_ADDR, 8'hff, 1'b0, 3'h0, 1'b0);
    rd(pssq_pkg::TABLE_RESULT_HIGH_ADDR, {1'b0, w[14:8]});
    issue(pssq_pkg::PSSQ_OP_TABL, 12'h000, 1'b0);
    nop(3);
    w = i_pssq_rom_model.word(12'hf35);
    rd(8'h40, w[7:0]);
    rd(pssq_pkg::TABLE_RESULT_HIGH_ADDR, {1'b0, w[14:8]});
    $display("test tables done");
    for (int i = 0; i < 5; i++) begin
      issue(pssq_pkg::PSSQ_OP_CALL, 12'(12'h100 + 16 * i), 1'b0);
      r.push_back(ip_o + 12'h001);
      nop(2);
    end
    chk("full", 15'(stack_full_o), 15'h1);
    tmr_req_i <= 1'b1;
    nop(3);
    tmr_req_i <= 1'b0;
    chk("held", 15'(acks), 15'h0);
    chk("pend", 15'(tmr_pend_o), 15'h1);
    issue(pssq_pkg::PSSQ_OP_RET, 12'h000, 1'b0);
    nop(1);
    chk("ret", 15'(ip_o), 15'(r[4]));
    nop(3);
    chk("served", 15'(ack_ip), 15'(pssq_pkg::TIMER_VECTOR));
    issue(pssq_pkg::PSSQ_OP_INTERRUPT_RETURN, 12'h000, 1'b0);
    nop(2);
    for (int j = 3; j >= 0; j--) begin
      issue(pssq_pkg::PSSQ_OP_RET, 12'h000, 1'b0);
      nop(1);
      if (j > 0) chk("ret", 15'(ip_o), 15'(r[j]));
      else chk("lost", 15'(ip_o === r[0]), 15'h0);
      nop(1);
    end
    $display("test stack done");
    usb_en_i <= 1'b0;
    usb_req_i <= 1'b1;
    tmr_req_i <= 1'b1;
    nop(4);
    chk("masked", 15'(ack_ip), 15'(pssq_pkg::TIMER_VECTOR));
    usb_en_i <= 1'b1;
    nop(4);
    usb_req_i <= 1'b0;
    tmr_req_i <= 1'b0;
    chk("usb", 15'(ack_ip), 15'(pssq_pkg::USB_VECTOR));
    issue(pssq_pkg::PSSQ_OP_INTERRUPT_RETURN, 12'h000, 1'b0);
    nop(4);
    chk("usb first", 15'(ack_ip), 15'(pssq_pkg::USB_VECTOR));
    issue(pssq_pkg::PSSQ_OP_INTERRUPT_RETURN, 12'h000, 1'b0);
    nop(4);
    chk("timer", 15'(ack_ip), 15'(pssq_pkg::TIMER_VECTOR));
    $display("test interrupts done");
    give_verdict();
  end
endmodule
